// *** core/qpc_position_regs.sv ***
// Behaviour
// - ccm 10/11 makes counters timers, init mode ignored
// - ccm 00 index match clears both counter halves
// - swap and polarity applied before index match
// - high word reads/writes counter bits 31:16
// - low word reads/writes counter bits 15:0
// - 16-bit read/write hold register for high word
// - match value bit selects matching phase level
`include "qpc_params.svh"

module qpc_position_regs
    import qpc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // wishbone slave
    input wire qpc_wb_req_s wbReq,
    output logic wbAck,
    output logic [31:0] wbDatO,
    // encoder inputs, already synchronous to ref_clk
    input wire qpc_enc_s enc
);

    // merge byte lanes of a 16-bit register with write data
    function automatic logic [15:0] laneMerge(input logic [15:0] old,
                                              input logic [31:0] wdat,
                                              input logic [3:0] sel);
        laneMerge = old;
        if (sel[0])
        begin
            laneMerge[7:0] = wdat[7:0];
        end
        if (sel[1])
        begin
            laneMerge[15:8] = wdat[15:8];
        end
    endfunction

    // bus state
    logic ack_q, ack_d; // answer flag, one cycle long
    logic [31:0] rdat_q, rdat_d; // read data, captured with ack
    // software state
    logic [15:0] ctrl_q, ctrl_d; // control word
    logic [15:0] hold_q, hold_d; // hold word for coherent access
    // counting state
    logic [31:0] count_q, count_d; // 32-bit position counter
    logic aPrev_q, bPrev_q, idxPrev_q; // last conditioned phase levels and raw index level
    logic aPrev_d, bPrev_d, idxPrev_d;

    // control fields
    logic enable;
    qpc_ccm_e counter_control_mode;
    qpc_pim_e pim;
    logic imvA, imvB, swapAB, polA, polB;
    assign enable = ctrl_q[`QPC_CTRL_EN_BIT];
    assign counter_control_mode = qpc_ccm_e'(ctrl_q[`QPC_CTRL_CCM_HI:`QPC_CTRL_CCM_LO]);
    assign pim = qpc_pim_e'(ctrl_q[`QPC_CTRL_PIM_HI:`QPC_CTRL_PIM_LO]);
    assign imvA = ctrl_q[`QPC_CTRL_IMVA_BIT];
    assign imvB = ctrl_q[`QPC_CTRL_IMVB_BIT];
    assign swapAB = ctrl_q[`QPC_CTRL_SWAP_BIT];
    assign polA = ctrl_q[`QPC_CTRL_POLA_BIT];
    assign polB = ctrl_q[`QPC_CTRL_POLB_BIT];

    // conditioned phases: swap first, then each polarity
    logic condA, condB;
    assign condA = (swapAB ? enc.phaseB : enc.phaseA) ^ polA;
    assign condB = (swapAB ? enc.phaseA : enc.phaseB) ^ polB;

    // match value bit picks the level each phase must show
    logic idxMatch;
    assign idxMatch = (condA == imvA) && (condB == imvB);

    // timer modes override everything position related
    logic timerMode;
    assign timerMode = (counter_control_mode == QPC_CCM_TMR0) || (counter_control_mode == QPC_CCM_TMR1);

    // bus phases: capture on the edge that raises ack, commit when
    // the master samples ack, so a write lands exactly once
    logic busReq, capture, commit;
    assign busReq = wbReq.cyc && wbReq.stb;
    assign capture = busReq && !ack_q;
    assign commit = busReq && ack_q && wbReq.we;

    logic wrCtrl, wrHigh, wrLow, wrHold, rdLow;
    assign wrCtrl = commit && (wbReq.adr == `QPC_OFF_CTRL);
    assign wrHigh = commit && (wbReq.adr == `QPC_OFF_HIGH);
    assign wrLow = commit && (wbReq.adr == `QPC_OFF_LOW);
    assign wrHold = commit && (wbReq.adr == `QPC_OFF_HOLD);
    assign rdLow = capture && !wbReq.we && (wbReq.adr == `QPC_OFF_LOW);

    // bus answer and read mux; unmapped reads give zero
    always_comb
    begin
        ack_d = capture;
        rdat_d = rdat_q;
        if (capture)
        begin
            rdat_d = 32'h0000_0000;
            unique case (wbReq.adr)
                `QPC_OFF_CTRL: rdat_d[15:0] = ctrl_q;
                `QPC_OFF_HIGH: rdat_d[15:0] = count_q[31:16];
                `QPC_OFF_LOW: rdat_d[15:0] = count_q[15:0];
                `QPC_OFF_HOLD: rdat_d[15:0] = hold_q;
                `QPC_OFF_STAT:
                begin
                    rdat_d[`QPC_STAT_A_BIT] = condA;
                    rdat_d[`QPC_STAT_B_BIT] = condB;
                    rdat_d[`QPC_STAT_MATCH_BIT] = idxMatch;
                    rdat_d[`QPC_STAT_TIMER_BIT] = timerMode;
                end
                default: rdat_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign wbAck = ack_q;
    assign wbDatO = rdat_q;

    // control and hold registers
    always_comb
    begin
        ctrl_d = ctrl_q;
        hold_d = hold_q;
        if (wrCtrl)
        begin
            ctrl_d = laneMerge(ctrl_q, wbReq.dat, wbReq.sel)
                & `QPC_CTRL_MASK;
        end
        if (wrHold)
        begin
            hold_d = laneMerge(hold_q, wbReq.dat, wbReq.sel);
        end
        else if (rdLow)
        begin
            // snapshot the upper half as the low half is read
            hold_d = count_q[31:16];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q <= `QPC_CTRL_RST;
            hold_q <= `QPC_WORD_RST;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            hold_q <= hold_d;
        end
    end

    // counting: software writes win over all, timer counts over clears, clears over encoder counts;
    // the encoder must stay below half of ref_clk or edges are lost
    logic aChg, bChg, idxRise;
    always_comb
    begin
        aPrev_d = condA;
        bPrev_d = condB;
        idxPrev_d = enc.index;
        aChg = condA ^ aPrev_q;
        bChg = condB ^ bPrev_q;
        idxRise = enc.index && !idxPrev_q;
        count_d = count_q;
        if (enable)
        begin
            if (timerMode)
            begin
                // init mode and index match play no part here
                count_d = count_q + 32'h0000_0001;
            end
            else if ((counter_control_mode == QPC_CCM_QUAD) && idxMatch)
            begin
                count_d = `QPC_COUNT_RST;
            end
            else if ((pim == QPC_PIM_IDXRST) && idxRise)
            begin
                count_d = `QPC_COUNT_RST;
            end
            else if (counter_control_mode == QPC_CCM_QUAD)
            begin
                // a double change is a skipped state and is dropped
                if (aChg ^ bChg)
                begin
                    if (condA ^ bPrev_q)
                    begin
                        count_d = count_q + 32'h0000_0001;
                    end
                    else
                    begin
                        count_d = count_q - 32'h0000_0001;
                    end
                end
            end
            else if (aChg && condA)
            begin
                // count and direction: phase B high counts up
                if (condB)
                begin
                    count_d = count_q + 32'h0000_0001;
                end
                else
                begin
                    count_d = count_q - 32'h0000_0001;
                end
            end
        end
        if (wrHigh)
        begin
            count_d[31:16] = laneMerge(count_q[31:16], wbReq.dat,
                                       wbReq.sel);
        end
        if (wrLow)
        begin
            count_d[15:0] = laneMerge(count_q[15:0], wbReq.dat,
                                      wbReq.sel);
            count_d[31:16] = hold_q;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_q <= `QPC_COUNT_RST;
            aPrev_q <= 1'b0;
            bPrev_q <= 1'b0;
            idxPrev_q <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            aPrev_q <= aPrev_d;
            bPrev_q <= bPrev_d;
            idxPrev_q <= idxPrev_d;
        end
    end

    // checks on the logic above
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    logic noWr;
    assign noWr = !wrHigh && !wrLow;

    a_timer_ignores_init: assert property (
        enable && timerMode && noWr
        |=> count_q == $past(count_q) + 32'h0000_0001)
        else $error("timer mode did not count by one");
    a_match_clears: assert property (
        enable && (counter_control_mode == QPC_CCM_QUAD) && idxMatch && noWr
        |=> count_q == 32'h0000_0000)
        else $error("index match did not clear counter");
    a_swap_polarity: assert property (
        swapAB && !polA && !polB && (counter_control_mode == QPC_CCM_QUAD)
        && (enc.phaseB == imvA) && (enc.phaseA == imvB) |-> idxMatch)
        else $error("swapped phases not used for match");
    a_match_level: assert property (
        !swapAB && !polA && (enc.phaseA != imvA) |-> !idxMatch)
        else $error("match seen with wrong phase A level");
    a_high_write: assert property (
        wrHigh && (wbReq.sel[1:0] == 2'b11)
        |=> count_q[31:16] == $past(wbReq.dat[15:0]))
        else $error("high word write lost");
    a_low_write: assert property (
        wrLow && (wbReq.sel[1:0] == 2'b11)
        |=> count_q == {$past(hold_q), $past(wbReq.dat[15:0])})
        else $error("low word write not coherent");
    a_hold_write: assert property (
        wrHold && (wbReq.sel[1:0] == 2'b11)
        |=> hold_q == $past(wbReq.dat[15:0]))
        else $error("hold write lost");
    a_low_read_snap: assert property (
        rdLow |=> hold_q == $past(count_q[31:16])
        && wbDatO[15:0] == $past(count_q[15:0]))
        else $error("low read did not snapshot high word");
    a_ack_timing: assert property (
        capture |=> wbAck ##1 !wbAck)
        else $error("ack not a single cycle after request");

    c_timer_run: cover property ((enable && timerMode) [*3]);
    c_index_init: cover property (enable && !timerMode
        && (pim == QPC_PIM_IDXRST) && idxRise);
    c_match_clear: cover property (enable && !timerMode && idxMatch);
    c_low_read: cover property (rdLow);
    c_low_write: cover property (wrLow);

endmodule

// *** core/qpc_params.svh ***
`ifndef QPC_PARAMS_SVH
`define QPC_PARAMS_SVH

// register word offsets (byte addresses, one aligned word each)
`define QPC_OFF_CTRL 8'h00
`define QPC_OFF_HIGH 8'h04
`define QPC_OFF_LOW 8'h08
`define QPC_OFF_HOLD 8'h0C
`define QPC_OFF_STAT 8'h10

// control register field positions
`define QPC_CTRL_EN_BIT 15
`define QPC_CTRL_PIM_HI 12
`define QPC_CTRL_PIM_LO 10
`define QPC_CTRL_IMVB_BIT 9
`define QPC_CTRL_IMVA_BIT 8
`define QPC_CTRL_CCM_HI 5
`define QPC_CTRL_CCM_LO 4
`define QPC_CTRL_SWAP_BIT 2
`define QPC_CTRL_POLA_BIT 1
`define QPC_CTRL_POLB_BIT 0
// writable bits of the control register
`define QPC_CTRL_MASK 16'h9F37

// status register field positions
`define QPC_STAT_A_BIT 0
`define QPC_STAT_B_BIT 1
`define QPC_STAT_MATCH_BIT 2
`define QPC_STAT_TIMER_BIT 3

// reset values
`define QPC_CTRL_RST 16'h0000
`define QPC_WORD_RST 16'h0000
`define QPC_COUNT_RST 32'h0000_0000

`endif

// *** core/qpc_pkg.sv ***
package qpc_pkg;

    // counter control modes
    typedef enum logic [1:0] {
        QPC_CCM_QUAD = 2'b00,
        QPC_CCM_DIR = 2'b01,
        QPC_CCM_TMR0 = 2'b10,
        QPC_CCM_TMR1 = 2'b11
    } qpc_ccm_e;

    // position init modes handled by this block
    typedef enum logic [2:0] {
        QPC_PIM_NONE = 3'b000,
        QPC_PIM_IDXRST = 3'b001
    } qpc_pim_e;

    // classic wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } qpc_wb_req_s;

    // encoder pins
    typedef struct packed {
        logic phaseA;
        logic phaseB;
        logic index;
    } qpc_enc_s;

endpackage

// *** tb/qpc_enc_model.sv ***
// behavioural incremental encoder: follows requested phase levels
module qpc_enc_model
    import qpc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // requested phase levels
    input wire logic lvlA,
    input wire logic lvlB,
    // requested index level
    input wire logic lvlIdx,
    // encoder pins toward the block
    output qpc_enc_s enc
);
    timeunit 1ns;
    timeprecision 1ps;

    logic holdOff; // quiet cycle after every phase edge

    // a real encoder never outruns the counting clock, so edges are spaced
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enc <= '0;
            holdOff <= 1'b0;
        end
        else
        begin
            // index follows its request one clock later, no spacing
            enc.index <= lvlIdx;
            if (holdOff)
            begin
                holdOff <= 1'b0;
            end
            else if ({lvlA, lvlB} != {enc.phaseA, enc.phaseB})
            begin
                enc.phaseA <= lvlA;
                enc.phaseB <= lvlB;
                holdOff <= 1'b1;
            end
        end
    end
endmodule

// *** tb/tb_quadrature_position_counter_regs.sv ***
`include "qpc_params.svh"

module tb_quadrature_position_counter_regs
    import qpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk;
    logic rst_n;
    qpc_wb_req_s wbReq;
    logic wbAck;
    logic [31:0] wbDatO;
    qpc_enc_s enc;
    logic lvlA; // requested encoder levels
    logic lvlB;
    logic lvlIdx; // requested index level
    int num_errors;
    int checks;
    int seed;
    int cycles; // watchdog count
    logic [31:0] rd;
    logic [31:0] rd2;
    logic [31:0] vr; // random draw
    logic [15:0] vh;
    logic [15:0] vl;
    logic [15:0] ctl;

    qpc_position_regs DUT (.ref_clk(ref_clk), .rst_n(rst_n), .wbReq(wbReq),
        .wbAck(wbAck), .wbDatO(wbDatO), .enc(enc));

    qpc_enc_model encModel (.ref_clk(ref_clk), .rst_n(rst_n), .lvlA(lvlA),
        .lvlB(lvlB), .lvlIdx(lvlIdx), .enc(enc));

    // free running 125 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // watchdog: the whole run needs well under two thousand cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic check(logic [31:0] seen, logic [31:0] expv);
        checks++;
        if (seen !== expv)
        begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask

    // one classic cycle; entered just after a rising edge, it leaves
    // cyc and stb low for one whole cycle before it returns
    task automatic bus(logic we, logic [7:0] adr, logic [15:0] wd,
        output logic [31:0] rdat);
        wbReq <= '{1'b1, 1'b1, we, adr, 4'h3, {16'h0000, wd}};
        // values read here are those sampled by this rising edge;
        // only the watchdog ends a wait that never sees ack
        do
        begin
            @(posedge ref_clk);
        end
        while (wbAck !== 1'b1);
        // ack is taken at this edge, then the request is dropped
        rdat = wbDatO;
        wbReq <= '0;
        @(posedge ref_clk);
    endtask

    task automatic wr(logic [7:0] adr, logic [15:0] wd);
        logic [31:0] dummy;
        bus(1'b1, adr, wd, dummy);
    endtask

    task automatic rdchk(logic [7:0] adr, logic [15:0] e);
        logic [31:0] v;
        bus(1'b0, adr, 16'h0000, v);
        check(v, {16'h0000, e});
    endtask

    // conditioned phase levels against the programmed match values
    function automatic logic match_exp(logic [15:0] c, logic a, logic b);
        logic ca;
        logic cb;
        ca = (c[2] ? b : a) ^ c[1];
        cb = (c[2] ? a : b) ^ c[0];
        return (ca == c[8]) && (cb == c[9]);
    endfunction

    // conditioned levels {b, a}: swap first, then each polarity
    function automatic logic [1:0] cond_exp(logic [15:0] c, logic a,
        logic b);
        cond_exp[0] = (c[2] ? b : a) ^ c[1];
        cond_exp[1] = (c[2] ? a : b) ^ c[0];
    endfunction

    // move the encoder, let the edge reach the counter, read low word
    task automatic step(logic a, logic b, logic [15:0] e);
        lvlA <= a;
        lvlB <= b;
        repeat (3) @(posedge ref_clk);
        rdchk(`QPC_OFF_LOW, e);
    endtask

    task automatic give_verdict();
        if (num_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        seed = 81;
        num_errors = 0;
        checks = 0;
        cycles = 0;
        rst_n = 1'b0;
        wbReq = '0;
        lvlA = 1'b0;
        lvlB = 1'b0;
        lvlIdx = 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        // reset values, unmapped place reads zero
        rdchk(`QPC_OFF_HIGH, 16'h0000);
        rdchk(`QPC_OFF_LOW, 16'h0000);
        rdchk(`QPC_OFF_HOLD, 16'h0000);
        rdchk(8'h14, 16'h0000);
        // direct and coherent word access with random data
        repeat (6)
        begin
            vr = $random(seed);
            vh = vr[31:16];
            vl = vr[15:0];
            wr(`QPC_OFF_HIGH, vh);
            rdchk(`QPC_OFF_HIGH, vh);
            wr(`QPC_OFF_HOLD, ~vh);
            rdchk(`QPC_OFF_HOLD, ~vh);
            wr(`QPC_OFF_LOW, vl);
            rdchk(`QPC_OFF_HIGH, ~vh);
            rdchk(`QPC_OFF_LOW, vl);
            wr(`QPC_OFF_HIGH, vh);
            rdchk(`QPC_OFF_LOW, vl);
            rdchk(`QPC_OFF_HOLD, vh);
        end
        // index match clear; configured while disabled so nothing counts
        repeat (16)
        begin
            vr = $random(seed);
            ctl = {6'h00, vr[9:8], 5'h00, vr[2:0]};
            lvlA <= vr[4];
            lvlB <= vr[5];
            wr(`QPC_OFF_CTRL, ctl);
            wr(`QPC_OFF_HOLD, 16'h5A5A);
            wr(`QPC_OFF_LOW, 16'hC3C3);
            wr(`QPC_OFF_CTRL, ctl | 16'h8000);
            repeat (3) @(posedge ref_clk);
            rdchk(`QPC_OFF_STAT, {13'h0000, match_exp(ctl, vr[4], vr[5]),
                cond_exp(ctl, vr[4], vr[5])});
            bus(1'b0, `QPC_OFF_LOW, 16'h0000, rd);
            bus(1'b0, `QPC_OFF_HOLD, 16'h0000, rd2);
            check({rd2[15:0], rd[15:0]}, match_exp(ctl, vr[4], vr[5]) ?
                32'h0000_0000 : 32'h5A5A_C3C3);
        end
        // quadrature steps that never reach the match state (both 1)
        lvlA <= 1'b0;
        lvlB <= 1'b0;
        wr(`QPC_OFF_CTRL, 16'h0300);
        wr(`QPC_OFF_HOLD, vh);
        wr(`QPC_OFF_LOW, vl);
        wr(`QPC_OFF_CTRL, 16'h8300);
        step(1'b1, 1'b0, vl + 16'h0001);
        step(1'b0, 1'b0, vl);
        step(1'b0, 1'b1, vl - 16'h0001);
        step(1'b0, 1'b0, vl);
        rdchk(`QPC_OFF_HOLD, vh);
        // direction mode: a matched state must not clear outside mode 00
        wr(`QPC_OFF_CTRL, 16'h8010);
        step(1'b1, 1'b1, vl + 16'h0001);
        step(1'b0, 1'b0, vl + 16'h0001);
        step(1'b1, 1'b0, vl);
        // init mode 001: an index rise clears both halves
        wr(`QPC_OFF_CTRL, 16'h8410);
        lvlIdx <= 1'b1;
        step(1'b1, 1'b0, 16'h0000);
        rdchk(`QPC_OFF_HOLD, 16'h0000);
        lvlIdx <= 1'b0;
        // timer modes: matched levels and an index rise must not clear
        lvlA <= 1'b0;
        lvlB <= 1'b0;
        for (int m = 2; m < 4; m++)
        begin
            ctl = 16'h8400 | {10'h000, m[1:0], 4'h0};
            wr(`QPC_OFF_CTRL, ctl);
            // the index rises between the two reads
            lvlIdx <= 1'b1;
            bus(1'b0, `QPC_OFF_LOW, 16'h0000, rd);
            bus(1'b0, `QPC_OFF_LOW, 16'h0000, rd2);
            lvlIdx <= 1'b0;
            check({16'h0000, rd2[15:0] - rd[15:0]}, 32'h0000_0003);
            rdchk(`QPC_OFF_STAT, 16'h000C);
        end
        give_verdict();
    end
endmodule
